/* File: pkg/abl_pkg.sv */
// shared constants and decode functions for the adaptive backlight parameter link
package abl_pkg;
    // command codes carried on the serial link
    localparam logic [7:0] CMD_UI_RATIO    = 8'h62;
    localparam logic [7:0] CMD_VS_FLOOR    = 8'h63;
    localparam logic [7:0] CMD_UI_FLOOR    = 8'h64;
    localparam logic [7:0] CMD_DIM_STEP    = 8'h65;
    localparam logic [7:0] CMD_NONE        = 8'h00;
    // parameter register index, offset from the first command code
    localparam logic [1:0] IDX_UI_RATIO    = 2'h0;
    localparam logic [1:0] IDX_VS_FLOOR    = 2'h1;
    localparam logic [1:0] IDX_UI_FLOOR    = 2'h2;
    localparam logic [1:0] IDX_DIM_STEP    = 2'h3;
    // bits that may be written per register, others read as zero
    localparam logic [7:0] MASK_UI_RATIO   = 8'h0F;
    localparam logic [7:0] MASK_VS_FLOOR   = 8'hFF;
    localparam logic [7:0] MASK_UI_FLOOR   = 8'h0F;
    localparam logic [7:0] MASK_DIM_STEP   = 8'hF7;
    // value of every parameter register after reset
    localparam logic [7:0] CFG_RESET       = 8'h00;
    // serial word: data/command flag then eight data bits
    localparam logic [3:0] WORD_BITS       = 4'h9;
    localparam int         DC_BIT          = 8;
    // adaptive mode setting
    localparam logic [1:0] MODE_OFF        = 2'h0;
    localparam logic [1:0] MODE_UI         = 2'h1;
    localparam logic [1:0] MODE_STILL      = 2'h2;
    localparam logic [1:0] MODE_MOVING     = 2'h3;
    // clock and serial timing
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         SCL_HALF_NS     = 50;
    localparam logic [3:0] SCL_HALF_CYC    = 4'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // backlight pwm: 8 MHz reference made from the 100 MHz clock
    localparam int         CLK_MHZ         = 100;
    localparam int         PWM_REF_MHZ     = 8;
    localparam logic [4:0] REF_INC         = 5'(PWM_REF_MHZ / REF_INC_DIV);
    localparam logic [4:0] REF_MOD         = 5'(CLK_MHZ / 4);
    localparam logic [7:0] REF_INC_DIV     = 8'h4;
    localparam logic [7:0] PWM_LAST_STEP   = 8'hFE;
    // host register map on the bus
    localparam logic [7:0] HOST_TX_OFS     = 8'h00;
    localparam logic [7:0] HOST_STATUS_OFS = 8'h04;

    // white ratio percent for user-interface images
    function automatic logic [6:0] ui_ratio_pct(input logic [3:0] code);
        ui_ratio_pct = (code == 4'h0) ? 7'd99 : 7'(7'd100 - {code, 1'b0});
    endfunction

    // threshold floor: base minus four per code
    function automatic logic [7:0] floor_dec(input logic [7:0] base, input logic [3:0] code);
        floor_dec = 8'(base - {2'h0, code, 2'h0});
    endfunction

    // log2 of the transition frame count
    function automatic logic [2:0] frames_shift(input logic [2:0] sel);
        frames_shift = (sel < 3'h2) ? 3'h0 : 3'(sel - 3'h1);
    endfunction
endpackage

/* File: pkg/abl_link_if.sv */
// three-line serial link between host controller and backlight device
`timescale 1ns/1ps
`default_nettype none
interface abl_link_if;
    logic csx_n;  // chip select, active low
    logic scl;    // serial clock, data taken on rising edge
    logic sda;    // serial data, host to device only
    modport host (output csx_n, output scl, output sda);
    modport dev  (input csx_n, input scl, input sda);
endinterface
`default_nettype wire

/* File: hdl/abl_host.sv */
// host end: bus registers; each write to the transmit offset while idle sends one serial word
`timescale 1ns/1ps
`default_nettype none
module abl_host (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // serial link
    abl_link_if.host         link
);
    // sender states, gray along idle-low-high-gap
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b11,
        ST_GAP  = 2'b10
    } abl_host_st_type;

    abl_host_st_type state, next_state;  // sender state
    logic [3:0]  timer, next_timer;       // half scl period count
    logic [3:0]  bitn, next_bitn;         // bits already clocked
    logic [8:0]  word, next_word;         // word being sent
    logic        wr_pend, next_wr_pend;   // write data phase due
    logic [7:0]  wr_ofs, next_wr_ofs;     // offset of that write
    logic [31:0] next_hrdata;             // read data for next phase
    logic        csx_q, next_csx;         // chip select drive
    logic        scl_q, next_scl;         // serial clock drive
    logic        sda_q, next_sda;         // serial data drive

    // bus decode, sender timing and pin drive
    always_comb begin
        logic addr_ph;
        addr_ph      = hsel && hready && htrans[1];
        next_wr_pend = addr_ph && hwrite;
        next_wr_ofs  = addr_ph ? haddr[7:0] : wr_ofs;
        next_hrdata  = 32'h0;
        if (addr_ph && !hwrite && haddr[7:0] == abl_pkg::HOST_TX_OFS) begin
            next_hrdata = {23'h0, word};
        end else if (addr_ph && !hwrite && haddr[7:0] == abl_pkg::HOST_STATUS_OFS) begin
            next_hrdata = {31'h0, state != ST_IDLE};
        end
        next_state = state;
        next_timer = timer;
        next_bitn  = bitn;
        next_word  = word;
        next_csx   = csx_q;
        next_scl   = scl_q;
        next_sda   = sda_q;
        case (state)
            ST_IDLE: begin
                // writes while busy are dropped
                if (wr_pend && wr_ofs == abl_pkg::HOST_TX_OFS) begin
                    next_word  = hwdata[8:0];
                    next_state = ST_LOW;
                    next_timer = 4'h1;
                    next_bitn  = 4'h0;
                    next_csx   = 1'b0;
                    next_sda   = hwdata[abl_pkg::DC_BIT];
                end
            end
            ST_LOW: begin
                // data settles while scl is low
                next_timer = timer + 4'h1;
                if (timer == abl_pkg::SCL_HALF_CYC) begin
                    next_timer = 4'h1;
                    if (bitn == abl_pkg::WORD_BITS) begin
                        next_state = ST_GAP;
                        next_csx   = 1'b1;
                    end else begin
                        next_state = ST_HIGH;
                        next_scl   = 1'b1;
                    end
                end
            end
            ST_HIGH: begin
                // device samples on this rising edge
                next_timer = timer + 4'h1;
                if (timer == abl_pkg::SCL_HALF_CYC) begin
                    next_timer = 4'h1;
                    next_state = ST_LOW;
                    next_scl   = 1'b0;
                    next_bitn  = bitn + 4'h1;
                    next_word  = {word[7:0], 1'b0};
                    next_sda   = word[7];
                end
            end
            ST_GAP: begin
                // chip select high between words
                next_timer = timer + 4'h1;
                if (timer == abl_pkg::SCL_HALF_CYC) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // register all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= ST_IDLE;
            timer     <= 4'h0;
            bitn      <= 4'h0;
            word      <= 9'h0;
            wr_pend   <= 1'b0;
            wr_ofs    <= 8'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            csx_q     <= 1'b1;
            scl_q     <= 1'b0;
            sda_q     <= 1'b0;
        end else begin
            state     <= next_state;
            timer     <= next_timer;
            bitn      <= next_bitn;
            word      <= next_word;
            wr_pend   <= next_wr_pend;
            wr_ofs    <= next_wr_ofs;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            csx_q     <= next_csx;
            scl_q     <= next_scl;
            sda_q     <= next_sda;
        end
    end

    assign link.csx_n = csx_q;
    assign link.scl   = scl_q;
    assign link.sda   = sda_q;
endmodule
`default_nettype wire

/* File: hdl/abl_dev.sv */
// device end: parameter registers and the brightness engine they steer
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - 0x62: upper nibble zero, lower UI ratio
// - UI ratio code: 99, then 100-2*code percent
// - UI threshold keeps white share at ratio
// - 0x63: upper moving floor, lower still floor
// - moving floor 224 minus 4 per code
// - still floor same decode, still mode only
// - 0x64: upper nibble zero, lower UI floor
// - UI floor 252 minus 4 per code
// - 0x65: min step, zero bit, frames select
// - transition frames 1,1,2,4,...,64 per code
// - hold brightness when min step exceeds gap
// - 2-bit mode picks which parameters apply
// - adaptive brightness never below minimum brightness; code only raises the target to it, so ramps and holds can stay below
// - pwm rate 8 MHz over (div+1)*255
module abl_dev (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // serial link
    abl_link_if.dev          link,
    // frame timing and mode
    input  wire logic        frame_start,
    input  wire logic [1:0]  adaptive_mode,
    // brightness settings from earlier commands
    input  wire logic [7:0]  adaptive_min_brightness,
    input  wire logic [7:0]  pwm_div,
    // image statistics
    input  wire logic [7:0]  measured_threshold,
    input  wire logic [7:0]  target_brightness,
    // results
    output logic [6:0]       ui_white_ratio_pct,
    output logic [7:0]       white_grayscale_threshold,
    output logic [7:0]       current_brightness,
    output logic             backlight_pwm_out
);
    logic [2:0] sync1, sync2;            // link pins, two stages
    logic       scl_prev;                // previous synced scl
    logic [3:0] bitcnt, next_bitcnt;     // bits of the current word
    logic [7:0] shreg, next_shreg;       // shifted-in bits
    logic [7:0] cmd, next_cmd;           // last command code
    logic [7:0] cfg_stage [4];           // written, not yet in force
    logic [7:0] cfg_act [4];             // parameters in force
    logic [7:0] next_stage [4];
    logic [7:0] next_act [4];
    logic [7:0] masks [4];               // writable bits per register

    assign masks[abl_pkg::IDX_UI_RATIO] = abl_pkg::MASK_UI_RATIO;
    assign masks[abl_pkg::IDX_VS_FLOOR] = abl_pkg::MASK_VS_FLOOR;
    assign masks[abl_pkg::IDX_UI_FLOOR] = abl_pkg::MASK_UI_FLOOR;
    assign masks[abl_pkg::IDX_DIM_STEP] = abl_pkg::MASK_DIM_STEP;

    // pin synchronisers; only the second stage is read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1    <= 3'b001;
            sync2    <= 3'b001;
            scl_prev <= 1'b0;
        end else begin
            sync1    <= {link.sda, link.scl, link.csx_n};
            sync2    <= sync1;
            scl_prev <= sync2[1];
        end
    end

    // word receiver and parameter registers
    always_comb begin
        logic [8:0] w;
        logic [1:0] idx;
        logic       hit;
        w           = {shreg, sync2[2]};
        idx         = 2'(cmd - abl_pkg::CMD_UI_RATIO);
        hit         = cmd >= abl_pkg::CMD_UI_RATIO && cmd <= abl_pkg::CMD_DIM_STEP;
        next_bitcnt = bitcnt;
        next_shreg  = shreg;
        next_cmd    = cmd;
        next_stage  = cfg_stage;
        next_act    = cfg_act;
        if (sync2[0]) begin
            // deselected: restart word framing
            next_bitcnt = 4'h0;
        end else if (sync2[1] && !scl_prev) begin
            next_shreg  = w[7:0];
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == abl_pkg::WORD_BITS - 4'h1) begin
                next_bitcnt = 4'h0;
                if (!w[abl_pkg::DC_BIT]) begin
                    next_cmd = w[7:0];
                end else if (hit) begin
                    // one byte per command; masked bits dropped
                    next_stage[idx] = w[7:0] & masks[idx];
                    next_cmd        = abl_pkg::CMD_NONE;
                end
            end
        end
        if (frame_start) begin
            next_act = next_stage;
        end
    end

    // register receiver state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bitcnt    <= 4'h0;
            shreg     <= 8'h0;
            cmd       <= abl_pkg::CMD_NONE;
            cfg_stage <= '{default: abl_pkg::CFG_RESET};
            cfg_act   <= '{default: abl_pkg::CFG_RESET};
        end else begin
            bitcnt    <= next_bitcnt;
            shreg     <= next_shreg;
            cmd       <= next_cmd;
            cfg_stage <= next_stage;
            cfg_act   <= next_act;
        end
    end

    logic [7:0] next_thr;     // threshold for the next cycle
    logic [6:0] next_pct;     // ratio for the next cycle

    // white threshold from statistics, floored per mode
    always_comb begin
        logic [7:0] flr;
        flr      = 8'hFF;
        next_pct = abl_pkg::ui_ratio_pct(cfg_act[abl_pkg::IDX_UI_RATIO][3:0]);
        case (adaptive_mode)
            abl_pkg::MODE_UI: begin
                flr = abl_pkg::floor_dec(8'd252, cfg_act[abl_pkg::IDX_UI_FLOOR][3:0]);
            end
            abl_pkg::MODE_STILL: begin
                flr = abl_pkg::floor_dec(8'd224, cfg_act[abl_pkg::IDX_VS_FLOOR][3:0]);
            end
            abl_pkg::MODE_MOVING: begin
                flr = abl_pkg::floor_dec(8'd224, cfg_act[abl_pkg::IDX_VS_FLOOR][7:4]);
            end
            default: begin
                flr = 8'hFF;
            end
        endcase
        // statistics engine searches at the ratio; floor is its lower limit
        next_thr = (measured_threshold > flr) ? measured_threshold : flr;
        if (adaptive_mode == abl_pkg::MODE_OFF) begin
            next_thr = 8'hFF;
        end
    end

    logic [7:0] tr_target, next_tr_target;  // brightness being reached
    logic [7:0] tr_step, next_tr_step;      // change per frame
    logic [6:0] tr_left, next_tr_left;      // frames still to go
    logic [7:0] next_bright;                // next brightness

    // brightness transitions, one step per frame
    always_comb begin
        logic [7:0] eff;
        logic [7:0] diff;
        logic [2:0] sh;
        logic [7:0] cur;
        eff  = target_brightness;
        cur  = current_brightness;
        if (adaptive_mode != abl_pkg::MODE_OFF && eff < adaptive_min_brightness) begin
            eff = adaptive_min_brightness;
        end
        diff = (eff > current_brightness) ? 8'(eff - current_brightness) : 8'(current_brightness - eff);
        sh   = abl_pkg::frames_shift(cfg_act[abl_pkg::IDX_DIM_STEP][2:0]);
        next_tr_target = tr_target;
        next_tr_step   = tr_step;
        next_tr_left   = tr_left;
        next_bright    = current_brightness;
        if (frame_start) begin
            if (tr_left == 7'h0 && eff != cur
                && {4'h0, cfg_act[abl_pkg::IDX_DIM_STEP][7:4]} <= diff) begin
                next_tr_target = eff;
                next_tr_step   = ((diff >> sh) == 8'h0) ? 8'h1 : (diff >> sh);
                next_tr_left   = 7'(7'h1 << sh);
            end else if (tr_left == 7'h1) begin
                // last frame lands exactly on target
                next_bright  = tr_target;
                next_tr_left = 7'h0;
            end else if (tr_left != 7'h0) begin
                next_tr_left = tr_left - 7'h1;
                if (tr_target > cur) begin
                    next_bright = (8'(tr_target - cur) > tr_step) ? 8'(cur + tr_step) : tr_target;
                end else begin
                    next_bright = (8'(cur - tr_target) > tr_step) ? 8'(cur - tr_step) : tr_target;
                end
            end
        end
    end

    logic [4:0] ref_acc, next_ref_acc;   // 8 MHz fractional phase
    logic [7:0] div_cnt, next_div_cnt;   // reference ticks per step
    logic [7:0] pos, next_pos;           // step within the pwm period
    logic       next_pwm;                // pwm level for next cycle

    // pwm: period of 255 steps of (div+1) reference ticks
    always_comb begin
        logic tick;
        tick         = ref_acc >= abl_pkg::REF_MOD - abl_pkg::REF_INC;
        next_ref_acc = tick ? 5'(ref_acc + abl_pkg::REF_INC - abl_pkg::REF_MOD)
                            : 5'(ref_acc + abl_pkg::REF_INC);
        next_div_cnt = div_cnt;
        next_pos     = pos;
        if (tick) begin
            next_div_cnt = div_cnt + 8'h1;
            if (div_cnt >= pwm_div) begin
                next_div_cnt = 8'h0;
                next_pos     = (pos >= abl_pkg::PWM_LAST_STEP) ? 8'h0 : pos + 8'h1;
            end
        end
        next_pwm = pos < current_brightness;
    end

    // register engine state and outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tr_target                 <= 8'h0;
            tr_step                   <= 8'h0;
            tr_left                   <= 7'h0;
            current_brightness        <= 8'h0;
            white_grayscale_threshold <= 8'hFF;
            ui_white_ratio_pct        <= 7'd99;
            ref_acc                   <= 5'h0;
            div_cnt                   <= 8'h0;
            pos                       <= 8'h0;
            backlight_pwm_out         <= 1'b0;
        end else begin
            tr_target                 <= next_tr_target;
            tr_step                   <= next_tr_step;
            tr_left                   <= next_tr_left;
            current_brightness        <= next_bright;
            white_grayscale_threshold <= next_thr;
            ui_white_ratio_pct        <= next_pct;
            ref_acc                   <= next_ref_acc;
            div_cnt                   <= next_div_cnt;
            pos                       <= next_pos;
            backlight_pwm_out         <= next_pwm;
        end
    end
endmodule
`default_nettype wire

/* File: verification/abl_link_asserts.sv */
// concurrent checks on the three-line serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module abl_link_asserts (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // serial link lines
    input  wire logic csx_n,
    input  wire logic scl,
    input  wire logic sda
);
    logic [3:0] rises;       // rising serial clock edges seen in this frame
    logic [3:0] next_rises;  // next value of the edge count
    logic       scl_q;       // serial clock one cycle back
    logic       next_scl_q;  // next value of the delayed clock

    // count serial clock rises, cleared while the device is not selected
    always_comb begin
        next_rises = rises;
        next_scl_q = scl;
        if (csx_n) begin
            next_rises = 4'h0;
        end else if (scl && !scl_q) begin
            next_rises = rises + 4'h1;
        end
    end

    // register the helper state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rises <= 4'h0;
            scl_q <= 1'b0;
        end else begin
            rises <= next_rises;
            scl_q <= next_scl_q;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // one low half of five cycles, then the clock rises
    sequence s_low_rise;
        (!scl)[*5] ##1 scl;
    endsequence
    // one high half of five cycles, then the clock falls
    sequence s_high_fall;
        scl[*5] ##1 !scl;
    endsequence

    property p_idle_clock;
        csx_n |-> !scl;
    endproperty
    property p_first_edge;
        $fell(csx_n) |-> s_low_rise;
    endproperty
    property p_high_half;
        $rose(scl) |-> s_high_fall;
    endproperty
    property p_low_half;
        $fell(scl) && (rises < 4'h9) |-> s_low_rise;
    endproperty
    property p_frame_end;
        $fell(scl) && (rises == 4'h9) |-> (!csx_n)[*5] ##1 csx_n;
    endproperty
    property p_gap;
        $rose(csx_n) |-> csx_n[*5];
    endproperty
    property p_data_hold;
        scl && !csx_n |-> $stable(sda);
    endproperty
    property p_word_len;
        $rose(scl) |-> rises < 4'h9;
    endproperty
    property p_select_hold;
        !csx_n && (rises < 4'h9) |=> !csx_n;
    endproperty

    a_idle_clock: assert property (p_idle_clock) else $error("serial clock moves while deselected");
    a_first_edge: assert property (p_first_edge) else $error("first clock rise not five cycles after select");
    a_high_half: assert property (p_high_half) else $error("serial clock high half not five cycles");
    a_low_half: assert property (p_low_half) else $error("serial clock low half not five cycles");
    a_frame_end: assert property (p_frame_end) else $error("select not released after ninth bit");
    a_gap: assert property (p_gap) else $error("deselect gap shorter than five cycles");
    a_data_hold: assert property (p_data_hold) else $error("data changed while serial clock high");
    a_word_len: assert property (p_word_len) else $error("more than nine bits in one frame");
    a_select_hold: assert property (p_select_hold) else $error("select released before nine bits");
endmodule
`default_nettype wire

/* File: verification/tb_adaptive_backlight_param_regs.sv */
// bench: host and device ends joined by the serial link, driven over the bus
`timescale 1ns/1ps
`default_nettype none
module tb_adaptive_backlight_param_regs;
    logic        hclk, hresetn, hsel, hwrite, frame_start, hreadyout, hresp, pwm;  // bus, frame control, pwm
    logic [1:0]  htrans, adaptive_mode;  // transfer kind and adaptive mode
    logic [2:0]  hsize;                  // transfer size, always word
    logic [31:0] haddr, hwdata, hrdata, rd;  // bus address, data, last read
    logic [7:0]  min_b, meas, target, thr, cur, pdiv;  // brightness, threshold and divider values
    logic [6:0]  pct;                    // ratio in force
    int          n_errors, num_checks;   // report counters

    abl_link_if link ();
    abl_host i_abl_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .link(link));
    abl_dev i_abl_dev (.hclk(hclk), .hresetn(hresetn), .link(link), .frame_start(frame_start),
        .adaptive_mode(adaptive_mode), .adaptive_min_brightness(min_b), .pwm_div(pdiv),
        .measured_threshold(meas), .target_brightness(target), .ui_white_ratio_pct(pct),
        .white_grayscale_threshold(thr), .current_brightness(cur), .backlight_pwm_out(pwm));
    abl_link_asserts i_abl_link_asserts (.hclk(hclk), .hresetn(hresetn), .csx_n(link.csx_n),
        .scl(link.scl), .sda(link.sda));

    // free-running bus clock
    always #5 hclk = ~hclk;

    // print counts and verdict, then stop
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // compare one result of up to sixteen bits
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // wait, bounded, until the slave is ready at a rising edge
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            results();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    // send one nine-bit word and poll status until the link is idle
    task automatic word(input logic [8:0] w);
        int k;
        bus(1'b1, 32'h0, {23'h0, w});
        k = 0;
        do begin
            bus(1'b0, 32'h4, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 200);
        if (k >= 200) begin
            n_errors++;
            results();
        end
    endtask

    // command word followed by its parameter word
    task automatic cmd(input logic [7:0] c, input logic [7:0] p);
        word({1'b0, c});
        word({1'b1, p});
    endtask

    // one frame boundary pulse, then let outputs settle
    task automatic frame;
        frame_start <= 1'b1;
        @(posedge hclk);
        frame_start <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // every ratio code, with junk in the upper nibble
    task automatic t_ratio;
        logic [7:0] e;
        adaptive_mode <= abl_pkg::MODE_UI;
        for (int c = 0; c < 16; c++) begin
            cmd(abl_pkg::CMD_UI_RATIO, {4'hA, 4'(c)});
            frame();
            e = (c == 0) ? 8'h63 : 8'(8'h64 - 8'(2 * c));
            chk("ui_white_ratio_pct", e, {1'b0, pct});
        end
    endtask

    // threshold floors per mode and the frame-boundary update
    task automatic t_floor;
        meas <= 8'h00;
        frame();
        chk("threshold", 8'hFC, thr);
        cmd(abl_pkg::CMD_UI_FLOOR, 8'hF3);
        chk("threshold", 8'hFC, thr);
        frame();
        chk("threshold", 8'hF0, thr);
        cmd(abl_pkg::CMD_VS_FLOOR, 8'h7F);
        adaptive_mode <= abl_pkg::MODE_MOVING;
        frame();
        chk("threshold", 8'hC4, thr);
        adaptive_mode <= abl_pkg::MODE_STILL;
        frame();
        chk("threshold", 8'hA4, thr);
        meas <= 8'hFA;
        frame();
        chk("threshold", 8'hFA, thr);
        adaptive_mode <= abl_pkg::MODE_OFF;
        frame();
        chk("threshold", 8'hFF, thr);
    endtask

    // transition spread, minimum step hold and brightness floor
    task automatic t_dim;
        adaptive_mode <= abl_pkg::MODE_MOVING;
        cmd(abl_pkg::CMD_DIM_STEP, 8'h03);
        frame();
        target <= 8'h64;
        repeat (3) frame();
        chk("brightness", 8'h32, cur);
        repeat (2) frame();
        chk("brightness", 8'h64, cur);
        cmd(abl_pkg::CMD_DIM_STEP, 8'hFB);
        frame();
        target <= 8'h6E;
        repeat (6) frame();
        chk("brightness", 8'h64, cur);
        min_b <= 8'h78;
        repeat (6) frame();
        chk("brightness", 8'h78, cur);
    endtask

    // pwm high time over one clean period with divider one
    task automatic t_pwm;
        int n;
        pdiv <= 8'h01;
        n = 0;
        while (pwm !== 1'b0 && n < 8000) begin
            @(posedge hclk);
            n++;
        end
        while (pwm !== 1'b1 && n < 16000) begin
            @(posedge hclk);
            n++;
        end
        n = 0;
        while (pwm === 1'b1 && n < 8000) begin
            @(posedge hclk);
            n++;
        end
        chk("pwm high cycles", 16'(8'h78 * 2 * abl_pkg::CLK_MHZ / abl_pkg::PWM_REF_MHZ), 16'(n));
    endtask

    // reset, scenarios, verdict
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        frame_start = 1'b0;
        adaptive_mode = abl_pkg::MODE_OFF;
        min_b = 8'h00;
        pdiv = 8'h00;
        meas = 8'h00;
        target = 8'h00;
        n_errors = 0;
        num_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_ratio();
        t_floor();
        t_dim();
        t_pwm();
        bus(1'b0, 32'h8, 32'h0);
        chk("unmapped read", 8'h00, rd[7:0]);
        chk("response", 8'h00, {7'h0, hresp});
        results();
    end
endmodule
`default_nettype wire
